// [rtl/dct_pkg.sv]
package dct_pkg;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_SRC = 5'h04;
    localparam logic [4:0] OFS_DST = 5'h08;
    localparam logic [4:0] OFS_CMD = 5'h0C;
    localparam logic [4:0] OFS_RAW = 5'h10;
    localparam logic [4:0] OFS_STAT = 5'h14;

    // Field positions in channel_one_control_low
    localparam int SRC_BURST_LSB = 14;
    localparam int DST_BURST_LSB = 11;
    localparam int SRC_STEP_LSB = 9;
    localparam int DST_STEP_LSB = 7;
    localparam int SRC_W_LSB = 4;
    localparam int DST_W_LSB = 1;
    localparam int IRQ_EN_BIT = 0;

    // Bits 19:17 are reserved, upper fields are not part of this block
    localparam logic [31:0] CTRL_MASK = 32'h0001_FFFF;
    localparam logic [31:0] CTRL_RST = 32'h0000_4801;
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;

    // Raw status bits
    localparam int RAW_SRC_BIT = 0;
    localparam int RAW_DST_BIT = 1;
    localparam int RAW_W = 2;

    // Command register bits
    localparam int CMD_START_BIT = 0;
    localparam int CMD_BUSY_BIT = 0;

    // Address step codes
    localparam logic [1:0] STEP_INC = 2'b00;
    localparam logic [1:0] STEP_DEC = 2'b01;

    // AHB transfer types
    localparam logic [1:0] HTRANS_IDLE = 2'b00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_ADR,
        ST_RD_DAT,
        ST_WR_ADR,
        ST_WR_DAT
    } dct_state_t;

    // Items per burst: 000 is one item, then 4 doubling to 256
    function automatic logic [8:0] dct_burst_items(input logic [2:0] code);
        if (code == 3'h0) begin
            return 9'h001;
        end
        return 9'h002 << code;
    endfunction : dct_burst_items

    // Bytes per item: 8 to 128 bits, codes 101 and 11x are 256 bits
    function automatic logic [5:0] dct_item_bytes(input logic [2:0] code);
        if (code >= 3'h5) begin
            return 6'h20;
        end
        return 6'h01 << code;
    endfunction : dct_item_bytes

    function automatic logic [31:0] dct_be_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction : dct_be_merge

endpackage : dct_pkg

// [rtl/dct_addr_step.sv]
module dct_addr_step
    import dct_pkg::*;
#(
    parameter int AW = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Software load
    input wire logic load,
    input wire logic [AW-1:0] load_val,
    // Beat completion and step setup
    input wire logic advance,
    input wire logic [1:0] step_mode,
    input wire logic [2:0] item_width,
    // Current address
    output logic [AW-1:0] addr
);

    logic [AW-1:0] stride;

    // One item width per beat keeps consecutive beats on adjacent items
    assign stride = AW'(dct_item_bytes(item_width));

    // A software load wins over a beat in the same cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr <= AW'(ADDR_RST);
        end else if (load) begin
            addr <= load_val;
        end else if (advance) begin
            case (step_mode)
                STEP_INC: addr <= addr + stride;
                STEP_DEC: addr <= addr - stride;
                default: addr <= addr;
            endcase
        end
    end

endmodule : dct_addr_step

// [rtl/dct_channel_ctrl.sv]
// Overview of operation
// - Burst code sets items per burst request
// - Source address increments, decrements or holds
// - Destination address increments, decrements or holds
// - Source width drives hsize on reads, destination width on writes; resets to 000
// - Width codes decode 8 to 256 bits
// - Interrupt enable lets channel interrupts out
// - Enable masks output only; raw still records
module dct_channel_ctrl
    import dct_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Avalon-MM register slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Hardware burst request
    input wire logic src_burst_req,
    // AHB-lite master
    output logic [1:0] htrans,
    output logic [31:0] haddr,
    output logic [2:0] hsize,
    output logic hwrite,
    output logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hready,
    // Channel interrupt
    output logic chan_irq
);

    dct_state_t state;
    logic [31:0] channel_one_control_low;
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
    logic [RAW_W-1:0] raw_status;
    logic [8:0] beats_left;
    logic [8:0] dst_left;

    logic [2:0] src_burst_len;
    logic [2:0] dst_burst_len;
    logic [1:0] src_addr_step;
    logic [1:0] dst_addr_step;
    logic [2:0] src_item_width;
    logic [2:0] dst_item_width;
    logic chan_irq_mask_on;

    logic acc;
    logic acc_wr;
    logic busy;
    logic start;
    logic rd_beat;
    logic wr_beat;
    logic src_done;
    logic dst_done;
    logic [RAW_W-1:0] raw_set;
    logic [RAW_W-1:0] raw_clr;
    logic [31:0] rd_mux;

    assign src_burst_len = channel_one_control_low[SRC_BURST_LSB +: 3];
    assign dst_burst_len = channel_one_control_low[DST_BURST_LSB +: 3];
    assign src_addr_step = channel_one_control_low[SRC_STEP_LSB +: 2];
    assign dst_addr_step = channel_one_control_low[DST_STEP_LSB +: 2];
    assign src_item_width = channel_one_control_low[SRC_W_LSB +: 3];
    assign dst_item_width = channel_one_control_low[DST_W_LSB +: 3];
    assign chan_irq_mask_on = channel_one_control_low[IRQ_EN_BIT];

    // Bus access completes on the edge where waitrequest is low
    assign acc = (avs_read || avs_write) && !avs_waitrequest;
    assign acc_wr = acc && avs_write;

    assign busy = (state != ST_IDLE);
    assign start = !busy && (src_burst_req
        || (acc_wr && avs_address == OFS_CMD && avs_byteenable[0]
            && avs_writedata[CMD_START_BIT]));
    assign rd_beat = (state == ST_RD_DAT) && hready;
    assign wr_beat = (state == ST_WR_DAT) && hready;
    assign src_done = wr_beat && (beats_left == 9'h001);
    assign dst_done = wr_beat && (dst_left == 9'h001);

    // Fixed one-wait-state slave: waitrequest drops for one cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_comb begin
        case (avs_address)
            OFS_CTRL: rd_mux = channel_one_control_low;
            OFS_SRC: rd_mux = src_addr;
            OFS_DST: rd_mux = dst_addr;
            OFS_CMD: rd_mux = {31'h0, busy};
            OFS_RAW: rd_mux = {30'h0, raw_status};
            OFS_STAT: rd_mux = {30'h0, raw_status & {RAW_W{chan_irq_mask_on}}};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is captured a cycle early so it stands at the accept edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= rd_mux;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            channel_one_control_low <= CTRL_RST;
        end else if (acc_wr && avs_address == OFS_CTRL) begin
            channel_one_control_low <= dct_be_merge(channel_one_control_low,
                avs_writedata, avs_byteenable) & CTRL_MASK;
        end
    end

    dct_addr_step #(
        .AW(32)
    ) u_src_step (
        .clk(clk),
        .resetn(resetn),
        .load(acc_wr && avs_address == OFS_SRC),
        .load_val(dct_be_merge(src_addr, avs_writedata, avs_byteenable)),
        .advance(rd_beat),
        .step_mode(src_addr_step),
        .item_width(src_item_width),
        .addr(src_addr)
    );

    dct_addr_step #(
        .AW(32)
    ) u_dst_step (
        .clk(clk),
        .resetn(resetn),
        .load(acc_wr && avs_address == OFS_DST),
        .load_val(dct_be_merge(dst_addr, avs_writedata, avs_byteenable)),
        .advance(wr_beat),
        .step_mode(dst_addr_step),
        .item_width(dst_item_width),
        .addr(dst_addr)
    );

    // Each beat is one item read then one item written, no deeper buffer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            htrans <= HTRANS_IDLE;
            haddr <= 32'h0000_0000;
            hsize <= 3'h0;
            hwrite <= 1'b0;
            hwdata <= 32'h0000_0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_RD_ADR;
                        htrans <= HTRANS_NONSEQ;
                        haddr <= src_addr;
                        hsize <= src_item_width;
                        hwrite <= 1'b0;
                    end
                end
                ST_RD_ADR: begin
                    if (hready) begin
                        state <= ST_RD_DAT;
                        htrans <= HTRANS_IDLE;
                    end
                end
                ST_RD_DAT: begin
                    if (hready) begin
                        state <= ST_WR_ADR;
                        hwdata <= hrdata;
                        htrans <= HTRANS_NONSEQ;
                        haddr <= dst_addr;
                        hsize <= dst_item_width;
                        hwrite <= 1'b1;
                    end
                end
                ST_WR_ADR: begin
                    if (hready) begin
                        state <= ST_WR_DAT;
                        htrans <= HTRANS_IDLE;
                    end
                end
                ST_WR_DAT: begin
                    if (hready) begin
                        hwrite <= 1'b0;
                        if (beats_left == 9'h001) begin
                            state <= ST_IDLE;
                        end else begin
                            state <= ST_RD_ADR;
                            htrans <= HTRANS_NONSEQ;
                            haddr <= src_addr;
                            hsize <= src_item_width;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    htrans <= HTRANS_IDLE;
                end
            endcase
        end
    end

    // Source and destination bursts count items independently
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            beats_left <= 9'h001;
            dst_left <= 9'h001;
        end else if (start) begin
            beats_left <= dct_burst_items(src_burst_len);
            dst_left <= dct_burst_items(dst_burst_len);
        end else if (wr_beat) begin
            beats_left <= beats_left - 9'h001;
            if (dst_done) begin
                dst_left <= dct_burst_items(dst_burst_len);
            end else begin
                dst_left <= dst_left - 9'h001;
            end
        end
    end

    // Raw bits record regardless of the enable; a set beats a clear
    assign raw_set = {dst_done, src_done};
    assign raw_clr = (acc_wr && avs_address == OFS_RAW && avs_byteenable[0])
        ? avs_writedata[RAW_W-1:0] : '0;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            raw_status <= '0;
        end else begin
            raw_status <= (raw_status & ~raw_clr) | raw_set;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chan_irq <= 1'b0;
        end else begin
            chan_irq <= (|raw_status) && chan_irq_mask_on;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_start;
        start;
    endsequence

    sequence s_rd_beat;
        rd_beat && !(acc_wr && avs_address == OFS_SRC);
    endsequence

    sequence s_wr_beat;
        wr_beat && !(acc_wr && avs_address == OFS_DST);
    endsequence

    property p_src_burst_load;
        s_start |=> beats_left == dct_burst_items($past(src_burst_len));
    endproperty
    a_src_burst_load: assert property (p_src_burst_load)
        else $error("source burst count not loaded from code");

    property p_dst_burst_load;
        s_start |=> dst_left == dct_burst_items($past(dst_burst_len));
    endproperty
    a_dst_burst_load: assert property (p_dst_burst_load)
        else $error("destination burst count not loaded from code");

    property p_src_inc;
        s_rd_beat and src_addr_step == STEP_INC |=> src_addr ==
            $past(src_addr) + 32'(dct_item_bytes($past(src_item_width)));
    endproperty
    a_src_inc: assert property (p_src_inc)
        else $error("source address did not increment by item size");

    property p_src_hold;
        s_rd_beat and src_addr_step[1] |=> $stable(src_addr);
    endproperty
    a_src_hold: assert property (p_src_hold)
        else $error("fixed source address moved");

    property p_dst_dec;
        s_wr_beat and dst_addr_step == STEP_DEC |=> dst_addr ==
            $past(dst_addr) - 32'(dct_item_bytes($past(dst_item_width)));
    endproperty
    a_dst_dec: assert property (p_dst_dec)
        else $error("destination address did not decrement by item size");

    property p_rd_hsize;
        s_start |=> htrans == HTRANS_NONSEQ && !hwrite
            && hsize == $past(src_item_width) && haddr == $past(src_addr);
    endproperty
    a_rd_hsize: assert property (p_rd_hsize)
        else $error("source read not issued with source width");

    property p_wr_hsize;
        rd_beat |=> (hwrite && htrans == HTRANS_NONSEQ
            && hsize == $past(dst_item_width))
            ##1 (htrans == HTRANS_IDLE || !$past(hready));
    endproperty
    a_wr_hsize: assert property (p_wr_hsize)
        else $error("destination write not issued with destination width");

    property p_irq_masked;
        !chan_irq_mask_on |=> !chan_irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt raised while channel enable clear");

    property p_raw_records;
        src_done && !chan_irq_mask_on |=> raw_status[RAW_SRC_BIT];
    endproperty
    a_raw_records: assert property (p_raw_records)
        else $error("raw status lost an event while masked");

endmodule : dct_channel_ctrl

// [verif/dct_ahb_mem.sv]
module dct_ahb_mem (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // AHB-lite slave side
    input wire logic [1:0] htrans,
    input wire logic [31:0] haddr,
    input wire logic [2:0] hsize,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hready,
    // Wait-state control
    input wire logic slow
);
    timeunit 1ns;
    timeprecision 1ps;
    logic dp;
    logic dp_wr;
    logic [31:0] dp_a;
    logic [31:0] rnd;
    logic [2:0] dp_s;
    int seed = 72466;
    logic [31:0] rd_a[$];
    logic [31:0] wr_a[$];
    logic [31:0] wr_d[$];
    logic [2:0] rd_s[$];
    logic [2:0] wr_s[$];

    function automatic logic [31:0] pat(input logic [31:0] a);
        return {a[15:0], ~a[31:16]};
    endfunction : pat

    // Outside a completing read the bus shows the inverse, never stale data
    assign hrdata = (dp && !dp_wr && hready) ? pat(dp_a) : ~pat(dp_a);

    always @(posedge clk) rnd <= $random(seed);

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dp <= 1'b0;
            dp_wr <= 1'b0;
            dp_a <= 32'h0;
            dp_s <= 3'h0;
            hready <= 1'b1;
        end else begin
            if (hready) begin
                if (dp && dp_wr) begin
                    wr_a.push_back(dp_a);
                    wr_s.push_back(dp_s);
                    wr_d.push_back(hwdata);
                end
                if (dp && !dp_wr) begin
                    rd_a.push_back(dp_a);
                    rd_s.push_back(dp_s);
                end
                dp <= (htrans == 2'b10);
                dp_a <= haddr;
                dp_wr <= hwrite;
                dp_s <= hsize;
            end
            // Slow mode stretches both phases at random
            hready <= !slow || rnd[0];
        end
    end
endmodule : dct_ahb_mem

// [verif/testbench.sv]
module testbench
    import dct_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic src_burst_req = 1'b0;
    logic slow = 1'b0;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [2:0] hsize;
    logic hwrite;
    logic hready;
    logic chan_irq;
    int seed = 72466;
    int failures = 0;
    int n_tests = 0;
    logic [31:0] q;

    always #25 clk = ~clk;

    dct_channel_ctrl dut (.clk(clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .src_burst_req(src_burst_req),
        .htrans(htrans), .haddr(haddr), .hsize(hsize), .hwrite(hwrite),
        .hwdata(hwdata), .hrdata(hrdata), .hready(hready),
        .chan_irq(chan_irq));

    dct_ahb_mem mem (.clk(clk), .resetn(resetn), .htrans(htrans),
        .haddr(haddr), .hsize(hsize), .hwrite(hwrite), .hwdata(hwdata),
        .hrdata(hrdata), .hready(hready), .slow(slow));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 50);
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i >= 50) begin
            failures++;
            wrap_up();
        end
    endtask : bus

    function automatic int items(input logic [2:0] c);
        return (c == 3'h0) ? 1 : (2 << c);
    endfunction : items

    function automatic logic [31:0] nxt(input logic [31:0] a,
                                        input logic [1:0] st,
                                        input logic [2:0] w);
        logic [31:0] b;
        b = (w >= 3'h5) ? 32'h20 : (32'h1 << w);
        if (st == 2'b00) return a + b;
        if (st == 2'b01) return a - b;
        return a;
    endfunction : nxt

    task automatic run(input logic [2:0] sb, db, input logic [1:0] ss, ds,
                       input logic [2:0] sw, dw, input logic en, hw);
        logic [31:0] sa;
        logic [31:0] da;
        logic [31:0] r;
        int n;
        int k;
        sa = $random(seed);
        da = $random(seed);
        n = items(sb);
        bus(1'b1, OFS_CTRL, {15'h0, sb, db, ss, ds, sw, dw, en}, r);
        bus(1'b1, OFS_SRC, sa, r);
        bus(1'b1, OFS_DST, da, r);
        bus(1'b1, OFS_RAW, 32'h3, r);
        mem.rd_a.delete();
        mem.rd_s.delete();
        mem.wr_a.delete();
        mem.wr_s.delete();
        mem.wr_d.delete();
        if (hw) begin
            @(posedge clk);
            src_burst_req <= 1'b1;
            @(posedge clk);
            src_burst_req <= 1'b0;
        end else begin
            bus(1'b1, OFS_CMD, 32'h1, r);
        end
        k = 0;
        do begin
            bus(1'b0, OFS_CMD, 32'h0, r);
            k++;
        end while (r[0] !== 1'b0 && k < 2000);
        if (k >= 2000) begin
            failures++;
            wrap_up();
        end
        chk("reads", n, mem.rd_a.size());
        chk("writes", n, mem.wr_a.size());
        for (int i = 0; i < n && i < mem.wr_a.size(); i++) begin
            chk("src addr", sa, mem.rd_a[i]);
            chk("src size", {29'h0, sw}, {29'h0, mem.rd_s[i]});
            chk("dst addr", da, mem.wr_a[i]);
            chk("dst size", {29'h0, dw}, {29'h0, mem.wr_s[i]});
            chk("wdata", mem.pat(sa), mem.wr_d[i]);
            sa = nxt(sa, ss, sw);
            da = nxt(da, ds, dw);
        end
        bus(1'b0, OFS_SRC, 32'h0, r);
        chk("src final", sa, r);
        bus(1'b0, OFS_DST, 32'h0, r);
        chk("dst final", da, r);
        bus(1'b0, OFS_RAW, 32'h0, r);
        chk("raw", {30'h0, n >= items(db), 1'b1}, r);
        bus(1'b0, OFS_STAT, 32'h0, q);
        chk("stat", r & {32{en}}, q);
        chk("irq", {31'h0, en}, {31'h0, chan_irq});
        $display("test done burst %0d items %0d", sb, n);
    endtask : run

    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        chk("hsize rst", 32'h0, {29'h0, hsize});
        bus(1'b0, OFS_CTRL, 32'h0, q);
        chk("ctrl rst", 32'h0000_4801, q);
        bus(1'b0, 5'h18, 32'h0, q);
        chk("unmapped", 32'h0, q);
        $display("test done reset");
        // Every burst and destination width code once, every step code twice
        for (int i = 0; i < 8; i++) begin
            slow <= i[2];
            // Source width kept at 32 bits or less
            run(i[2:0], 3'(7 - i), i[1:0], 2'(3 - i), 3'(i % 3), i[2:0],
                i[0], i[1]);
        end
        for (int i = 0; i < 12; i++) begin
            slow <= 1'($random(seed));
            run(3'($random(seed)), 3'($random(seed)), 2'($random(seed)),
                2'($random(seed)), 3'($unsigned($random(seed)) % 3),
                3'($random(seed)), 1'($random(seed)), 1'($random(seed)));
        end
        bus(1'b1, OFS_RAW, 32'h3, q);
        bus(1'b0, OFS_RAW, 32'h0, q);
        chk("raw clr", 32'h0, q);
        chk("irq clr", 32'h0, {31'h0, chan_irq});
        $display("test done clear");
        // Only the enabled lanes land, and reserved bits read back as zero
        bus(1'b1, OFS_CTRL, 32'h0, q);
        avs_byteenable <= 4'h6;
        bus(1'b1, OFS_CTRL, 32'hFFFF_FFFF, q);
        avs_byteenable <= 4'hF;
        bus(1'b0, OFS_CTRL, 32'h0, q);
        chk("ctrl lanes", 32'h0001_FF00, q);
        $display("test done lanes");
        wrap_up();
    end
endmodule : testbench
